// [shared/rsq_map.vh]
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH

// timing: figures in their own unit, cycle counts at the 10 ns clock
`define RSQ_CLK_NS        10
`define RSQ_POWER_ON_DELAY_US       10
`define RSQ_REGULATOR_DELAY_US      10
`define RSQ_POWER_UP_TIMER_DELAY_MS      64
`define RSQ_TRST_US       20
`define RSQ_PLL_LOCK_TIME_US      20
`define RSQ_CLOCK_MONITOR_DELAY_US      100
`define RSQ_POWER_ON_DELAY_CYC      ((`RSQ_POWER_ON_DELAY_US * 1000) / `RSQ_CLK_NS)
`define RSQ_REGULATOR_DELAY_CYC     ((`RSQ_REGULATOR_DELAY_US * 1000) / `RSQ_CLK_NS)
`define RSQ_POWER_UP_TIMER_DELAY_CYC     ((`RSQ_POWER_UP_TIMER_DELAY_MS * 1000000) / `RSQ_CLK_NS)
`define RSQ_TRST_CYC      ((`RSQ_TRST_US * 1000) / `RSQ_CLK_NS)
`define RSQ_PLL_LOCK_TIME_CYC     ((`RSQ_PLL_LOCK_TIME_US * 1000) / `RSQ_CLK_NS)
`define RSQ_CLOCK_MONITOR_DELAY_CYC     ((`RSQ_CLOCK_MONITOR_DELAY_US * 1000) / `RSQ_CLK_NS)
`define RSQ_TMR_W         23
`define RSQ_OST_W         10
`define RSQ_OST_LAST      10'h3FF

// register offsets (byte addresses, one 32-bit word each)
`define RSQ_AW            8
`define RSQ_OFS_STATUS    8'h00
`define RSQ_OFS_OSCCTL    8'h04
`define RSQ_OFS_CALIB     8'h08
`define RSQ_OFS_FLASH     8'h0C
`define RSQ_OFS_SEQ       8'h10

// reset_cause_status fields
`define RSQ_B_TRAP        15
`define RSQ_B_BADOP       14
`define RSQ_B_CM          9
`define RSQ_B_VREG        8
`define RSQ_B_PIN         7
`define RSQ_B_SOFT        6
`define RSQ_B_SWDT        5
`define RSQ_B_WATCHDOG_TIMEOUT_FLAG        4
`define RSQ_B_SLEEP       3
`define RSQ_B_IDLE        2
`define RSQ_B_BOR         1
`define RSQ_B_POR         0
`define RSQ_STAT_POR_VAL  16'h0003
`define RSQ_STAT_MASK     16'hC3FF

// oscillator_control fields and source codes
`define RSQ_OSC_LSB       12
`define RSQ_OSC_FAIL_BIT  3
`define RSQ_OSC_FRC       3'h0
`define RSQ_OSC_FRCPLL    3'h1
`define RSQ_OSC_PRI       3'h2
`define RSQ_OSC_PRIPLL    3'h3
`define RSQ_OSC_SOSC      3'h4

`define RSQ_RESP_OKAY     2'b00
`define RSQ_RESP_SLVERR   2'b10

`endif

// [core/rsq_timer.v]
`default_nettype none

// one-shot down counter: done rises load_val cycles after load
module rsq_timer #(
	parameter W = 23
) (
	input  wire         clk,      // system clock
	input  wire         rst,      // synchronous reset
	input  wire         ce,       // clock enable
	input  wire         load,     // start a new delay
	input  wire [W-1:0] load_val, // delay in cycles, at least one
	output reg          done      // delay expired, level
);
	reg [W-1:0] cnt;

	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt  <= {W{1'b0}};
			done <= 1'b1;
		end
		else if (ce)
		begin
			if (load)
			begin
				cnt  <= load_val;
				done <= 1'b0;
			end
			else if (!done)
			begin
				cnt  <= cnt - {{(W-1){1'b0}}, 1'b1};
				done <= (cnt == {{(W-1){1'b0}}, 1'b1});
			end
		end
	end
endmodule

`default_nettype wire

// [core/rsq_top.v]
`default_nettype none
`include "rsq_map.vh"

module rsq_top #(
	parameter [31:0] POWER_UP_TIMER_CYCLES = `RSQ_POWER_UP_TIMER_DELAY_CYC,
	parameter [31:0] CLOCK_FAIL_MONITOR_CYCLES = `RSQ_CLOCK_MONITOR_DELAY_CYC
) (
	input  wire                 clk,                    // 100 MHz clock
	input  wire                 rst,                    // power-on reset, sync high
	input  wire                 ce,                     // clock enable
	input  wire [`RSQ_AW-1:0]   s_axi_awaddr,           // write address
	input  wire                 s_axi_awvalid,          // write address valid
	output reg                  s_axi_awready,          // write address ready
	input  wire [31:0]          s_axi_wdata,            // write data
	input  wire [3:0]           s_axi_wstrb,            // write byte strobes
	input  wire                 s_axi_wvalid,           // write data valid
	output reg                  s_axi_wready,           // write data ready
	output reg  [1:0]           s_axi_bresp,            // write response
	output reg                  s_axi_bvalid,           // write response valid
	input  wire                 s_axi_bready,           // write response ready
	input  wire [`RSQ_AW-1:0]   s_axi_araddr,           // read address
	input  wire                 s_axi_arvalid,          // read address valid
	output reg                  s_axi_arready,          // read address ready
	output reg  [31:0]          s_axi_rdata,            // read data
	output reg  [1:0]           s_axi_rresp,            // read response
	output reg                  s_axi_rvalid,           // read data valid
	input  wire                 s_axi_rready,           // read data ready
	input  wire                 master_clear_pin_n,     // reset pin, low active
	input  wire                 brownout_in,            // supply monitor, high active
	input  wire                 osc_in,                 // oscillator, sampled
	input  wire                 watchdog_timeout,       // watchdog expiry
	input  wire                 soft_reset_req,         // reset instruction
	input  wire                 trap_conflict_req,      // trap conflict
	input  wire                 bad_opcode_req,         // illegal opcode
	input  wire                 uninit_wreg_req,        // uninitialised w register
	input  wire                 config_mismatch_req,    // configuration mismatch
	input  wire                 sleep_instr,            // power save, sleep
	input  wire                 idle_instr,             // power save, idle
	input  wire                 watchdog_fuse_enable,   // fuse, 1 = unprogrammed
	input  wire                 regulator_enable,       // on-chip regulator on
	input  wire                 clk_switch_enable,      // clock switching allowed
	input  wire [2:0]           initial_osc_select,     // config word two 10:8
	input  wire                 pri_is_crystal,         // primary osc is a crystal
	input  wire                 clock_fail_monitor_en,  // clock monitor enabled
	output reg                  master_system_reset,    // system reset, high
	output reg                  cpu_run,                // cpu may execute
	output reg                  sys_clk_ready,          // valid clock released
	output reg  [2:0]           current_osc_select,     // selected clock source
	output reg                  watchdog_enable,        // watchdog running
	output reg                  regulator_sleep_keep,   // regulator stays on in sleep
	output reg                  clock_monitor_active,   // clock monitor watching
	output reg                  clock_fail_switched     // fell back to fast rc
);
	localparam [2:0] S_HOLD  = 3'd0;
	localparam [2:0] S_POR   = 3'd1;
	localparam [2:0] S_START = 3'd2;
	localparam [2:0] S_INT   = 3'd3;
	localparam [2:0] S_RUN   = 3'd4;
	localparam [1:0] K_OTH   = 2'd0;
	localparam [1:0] K_BOR   = 2'd1;
	localparam [1:0] K_POR   = 2'd2;
	localparam [2:0] SEL_STATUS = 3'd0;
	localparam [2:0] SEL_OSC    = 3'd1;
	localparam [2:0] SEL_CALIB  = 3'd2;
	localparam [2:0] SEL_FLASH  = 3'd3;
	localparam [2:0] SEL_SEQ    = 3'd4;
	localparam [2:0] SEL_NONE   = 3'd7;
	localparam [31:0] POWER_ON_DELAY_C  = `RSQ_POWER_ON_DELAY_CYC;
	localparam [31:0] REGULATOR_DELAY_C = `RSQ_REGULATOR_DELAY_CYC;
	localparam [31:0] TRST_C  = `RSQ_TRST_CYC;
	localparam [31:0] PLL_LOCK_TIME_C = `RSQ_PLL_LOCK_TIME_CYC;

	function [2:0] reg_sel;
		input [`RSQ_AW-1:0] a;
		begin
			case (a)
				`RSQ_OFS_STATUS: reg_sel = SEL_STATUS;
				`RSQ_OFS_OSCCTL: reg_sel = SEL_OSC;
				`RSQ_OFS_CALIB:  reg_sel = SEL_CALIB;
				`RSQ_OFS_FLASH:  reg_sel = SEL_FLASH;
				`RSQ_OFS_SEQ:    reg_sel = SEL_SEQ;
				default:         reg_sel = SEL_NONE;
			endcase
		end
	endfunction

	function needs_ost;
		input [2:0] sel;
		input       xtal;
		begin
			needs_ost = (sel == `RSQ_OSC_SOSC) ||
				(xtal && (sel == `RSQ_OSC_PRI || sel == `RSQ_OSC_PRIPLL));
		end
	endfunction

	function needs_pll;
		input [2:0] sel;
		begin
			needs_pll = (sel == `RSQ_OSC_FRCPLL) || (sel == `RSQ_OSC_PRIPLL);
		end
	endfunction

	// pins from outside the clock domain: two flops before any use
	reg  [2:0] sync1;
	reg  [2:0] sync2;
	reg        osc_prev;
	wire       master_clear_pin_n_s = sync2[0];
	wire       bor_s    = sync2[1];
	wire       osc_s    = sync2[2];

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [1:0]  kind;
	reg  [1:0]  next_kind;
	reg         rt_load;
	reg  [22:0] rt_val;
	wire        rt_done;
	reg  [15:0] stat;
	reg  [15:0] next_stat;
	reg  [15:0] calib;
	reg  [15:0] flash;
	reg  [2:0]  next_osc;
	reg  [`RSQ_OST_W-1:0] ost_cnt;
	reg         ost_done;
	reg         pll_need;
	wire        lock_done;
	wire        clock_fail_monitor_done;
	reg         mon_wait;
	reg         fail_flag;

	reg               aw_held;
	reg               w_held;
	reg [`RSQ_AW-1:0] aw_addr;
	reg [15:0]        w_data;
	reg [1:0]         w_strb;

	wire [22:0] startup_c = regulator_enable ? REGULATOR_DELAY_C[22:0] : POWER_UP_TIMER_CYCLES[22:0];
	wire src_pin  = ~master_clear_pin_n_s;
	wire src_any  = src_pin | bor_s | watchdog_timeout | soft_reset_req |
		trap_conflict_req | bad_opcode_req | uninit_wreg_req | config_mismatch_req;
	wire [1:0] src_kind   = bor_s ? K_BOR : K_OTH;
	wire       leave_hold = (state == S_HOLD) && !src_any;
	wire       clk_restart = leave_hold && (kind != K_OTH);
	wire       release_now = (state != S_RUN) && (next_state == S_RUN);
	wire       osc_edge = osc_s & ~osc_prev;
	wire       wr_commit = aw_held && w_held && !s_axi_bvalid;
	wire [2:0] wr_sel = reg_sel(aw_addr);
	wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire       fail_switch = clock_monitor_active && clock_fail_monitor_en &&
		!sys_clk_ready && (current_osc_select != `RSQ_OSC_FRC);

	// reset sequencer
	always @*
	begin
		next_state = state;
		next_kind  = kind;
		rt_load    = 1'b0;
		rt_val     = TRST_C[22:0];
		if (src_any)
		begin
			next_state = S_HOLD;
			// a pending power-on or brownout sequence is not downgraded
			next_kind  = (state == S_RUN || src_kind > kind) ? src_kind : kind;
		end
		else
		begin
			case (state)
				S_HOLD:
				begin
					rt_load = 1'b1;
					if (kind == K_POR)
					begin
						next_state = S_POR;
						rt_val     = POWER_ON_DELAY_C[22:0];
					end
					else if (kind == K_BOR)
					begin
						next_state = S_START;
						rt_val     = startup_c;
					end
					else
						next_state = S_INT;
				end
				S_POR:
					if (rt_done)
					begin
						next_state = S_START;
						rt_load    = 1'b1;
						rt_val     = startup_c;
					end
				S_START:
					if (rt_done)
					begin
						next_state = S_INT;
						rt_load    = 1'b1;
					end
				S_INT:
					if (rt_done)
						next_state = S_RUN;
				S_RUN:
					next_state = S_RUN;
				default:
					next_state = S_HOLD;
			endcase
		end
	end

	rsq_timer #(.W(`RSQ_TMR_W)) u_rst_tmr (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.load     (rt_load),
		.load_val (rt_val),
		.done     (rt_done)
	);

	// lock timer starts with the reset delay, not after it
	rsq_timer #(.W(`RSQ_TMR_W)) u_lock_tmr (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.load     (clk_restart),
		.load_val (PLL_LOCK_TIME_C[22:0]),
		.done     (lock_done)
	);

	rsq_timer #(.W(`RSQ_TMR_W)) u_clock_fail_monitor_tmr (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.load     (release_now),
		.load_val (CLOCK_FAIL_MONITOR_CYCLES[22:0]),
		.done     (clock_fail_monitor_done)
	);

	// clock source choice at reset release of the hold
	always @*
	begin
		next_osc = current_osc_select;
		if (leave_hold && (kind != K_OTH || !clk_switch_enable))
			next_osc = initial_osc_select;
		else if (fail_switch)
			next_osc = `RSQ_OSC_FRC;
	end

	// status: software merge first, hardware sets last so an event wins
	always @*
	begin
		next_stat = stat;
		if (wr_commit && wr_sel == SEL_STATUS)
			next_stat = (stat & ~wmask) | (w_data & wmask);
		if (sleep_instr || idle_instr)
			next_stat[`RSQ_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		if (bor_s)
			next_stat[`RSQ_B_BOR] = 1'b1;
		if (src_pin)
			next_stat[`RSQ_B_PIN] = 1'b1;
		if (soft_reset_req)
			next_stat[`RSQ_B_SOFT] = 1'b1;
		if (watchdog_timeout)
			next_stat[`RSQ_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (trap_conflict_req)
			next_stat[`RSQ_B_TRAP] = 1'b1;
		if (bad_opcode_req || uninit_wreg_req)
			next_stat[`RSQ_B_BADOP] = 1'b1;
		if (config_mismatch_req)
			next_stat[`RSQ_B_CM] = 1'b1;
		if (sleep_instr)
			next_stat[`RSQ_B_SLEEP] = 1'b1;
		if (idle_instr)
			next_stat[`RSQ_B_IDLE] = 1'b1;
		next_stat = next_stat & `RSQ_STAT_MASK;
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			// idle pin levels: a zero here would fake a pin reset after power-on
			sync1 <= 3'h1;
			sync2 <= 3'h1;
			osc_prev <= 1'b0;
			// power-on enters the hold; sequence starts once sources are quiet
			state <= S_HOLD;
			kind  <= K_POR;
			stat  <= `RSQ_STAT_POR_VAL;
			calib <= 16'h0000;
			flash <= 16'h0000;
			current_osc_select   <= `RSQ_OSC_FRC;
			ost_cnt              <= {`RSQ_OST_W{1'b0}};
			ost_done             <= 1'b0;
			pll_need             <= 1'b0;
			mon_wait             <= 1'b0;
			fail_flag            <= 1'b0;
			master_system_reset  <= 1'b1;
			cpu_run              <= 1'b0;
			sys_clk_ready        <= 1'b0;
			watchdog_enable      <= 1'b0;
			regulator_sleep_keep <= 1'b0;
			clock_monitor_active <= 1'b0;
			clock_fail_switched  <= 1'b0;
		end
		else if (ce)
		begin
			sync1    <= {osc_in, brownout_in, master_clear_pin_n};
			sync2    <= sync1;
			osc_prev <= osc_s;
			state    <= next_state;
			kind     <= next_kind;
			stat     <= next_stat;
			current_osc_select <= next_osc;
			if (wr_commit && wr_sel == SEL_CALIB)
				calib <= (calib & ~wmask) | (w_data & wmask);
			if (wr_commit && wr_sel == SEL_FLASH)
				flash <= (flash & ~wmask) | (w_data & wmask);

			// crystal start counter: 1024 sampled oscillator edges
			if (clk_restart)
			begin
				ost_cnt  <= {`RSQ_OST_W{1'b0}};
				ost_done <= !needs_ost(next_osc, pri_is_crystal);
				pll_need <= needs_pll(next_osc);
			end
			else if (fail_switch)
			begin
				ost_done <= 1'b1;
				pll_need <= 1'b0;
			end
			else if (!ost_done && osc_edge)
			begin
				ost_cnt  <= ost_cnt + {{(`RSQ_OST_W-1){1'b0}}, 1'b1};
				ost_done <= (ost_cnt == `RSQ_OST_LAST);
			end

			// other resets leave the clock ready; they keep the running source only while clock switching is allowed
			if (clk_restart)
				sys_clk_ready <= 1'b0;
			else
				sys_clk_ready <= fail_switch ||
					(ost_done && (lock_done || !pll_need));

			// monitor waits after release for crystal or pll sources
			if (next_state != S_RUN)
			begin
				clock_monitor_active <= 1'b0;
				mon_wait             <= 1'b0;
			end
			else if (release_now)
			begin
				mon_wait <= needs_ost(current_osc_select, pri_is_crystal) ||
					needs_pll(current_osc_select);
				clock_monitor_active <= !(needs_ost(current_osc_select,
					pri_is_crystal) || needs_pll(current_osc_select));
			end
			else if (mon_wait && clock_fail_monitor_done)
			begin
				mon_wait             <= 1'b0;
				clock_monitor_active <= 1'b1;
			end

			if (fail_switch)
				fail_flag <= 1'b1;
			clock_fail_switched  <= fail_flag | fail_switch;
			master_system_reset  <= (next_state != S_RUN);
			cpu_run              <= !master_system_reset && sys_clk_ready;
			watchdog_enable      <= watchdog_fuse_enable | next_stat[`RSQ_B_SWDT];
			regulator_sleep_keep <= next_stat[`RSQ_B_VREG];
		end
	end

	// register bus write side: address and data in either order
	always @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RSQ_RESP_OKAY;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= {`RSQ_AW{1'b0}};
			w_data  <= 16'h0000;
			w_strb  <= 2'b00;
		end
		else if (ce)
		begin
			if (!aw_held && !s_axi_bvalid)
				s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
			if (!w_held && !s_axi_bvalid)
				s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata[15:0];
				w_strb <= s_axi_wstrb[1:0];
			end
			if (wr_commit)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// read-only and unmapped words answer with an error
				s_axi_bresp  <= (wr_sel == SEL_NONE || wr_sel == SEL_OSC ||
					wr_sel == SEL_SEQ) ? `RSQ_RESP_SLVERR : `RSQ_RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// register bus read side
	always @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RSQ_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RSQ_RESP_OKAY;
				s_axi_rdata   <= 32'h0000_0000;
				case (reg_sel(s_axi_araddr))
					SEL_STATUS: s_axi_rdata[15:0] <= stat;
					SEL_OSC:
					begin
						s_axi_rdata[`RSQ_OSC_LSB+2:`RSQ_OSC_LSB] <= current_osc_select;
						s_axi_rdata[`RSQ_OSC_FAIL_BIT] <= fail_flag;
					end
					SEL_CALIB:  s_axi_rdata[15:0] <= calib;
					SEL_FLASH:  s_axi_rdata[15:0] <= flash;
					SEL_SEQ:    s_axi_rdata[7:0]  <= {clock_monitor_active,
						sys_clk_ready, kind, 1'b0, state};
					default:    s_axi_rresp <= `RSQ_RESP_SLVERR;
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// [testbench/rsq_top_checker.sv]
`default_nettype none
`include "rsq_map.vh"

module rsq_top_checker #(
	parameter [31:0] POWER_UP_TIMER_CYCLES = 32'h0000_0032
) (
	input wire logic        clk,                  // clock
	input wire logic        rst,                  // reset
	input wire logic        s_axi_awvalid,        // aw valid
	input wire logic        s_axi_awready,        // aw ready
	input wire logic        s_axi_wvalid,         // w valid
	input wire logic        s_axi_wready,         // w ready
	input wire logic        s_axi_bvalid,         // b valid
	input wire logic [7:0]  s_axi_araddr,         // ar addr
	input wire logic        s_axi_arvalid,        // ar valid
	input wire logic        s_axi_arready,        // ar ready
	input wire logic [31:0] s_axi_rdata,          // r data
	input wire logic [1:0]  s_axi_rresp,          // r resp
	input wire logic        s_axi_rvalid,         // r valid
	input wire logic        s_axi_rready,         // r ready
	input wire logic        soft_reset_req,       // reset instr
	input wire logic        watchdog_fuse_enable, // fuse
	input wire logic        regulator_enable,     // regulator
	input wire logic        master_system_reset,  // sys reset
	input wire logic        cpu_run,              // cpu runs
	input wire logic        sys_clk_ready,        // clock ok
	input wire logic        watchdog_enable       // wdt on
);
	logic [31:0] hi_cnt;
	logic        por_seq;
	wire  [31:0] st = regulator_enable ? 32'h0000_03E8 : POWER_UP_TIMER_CYCLES;

	// length of the current high phase of the system reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hi_cnt <= 32'h0000_0000;
			por_seq <= 1'b1;
		end
		else
		begin
			hi_cnt <= master_system_reset ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
			if (!master_system_reset)
				por_seq <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_src_holds_rst: assert property (soft_reset_req |-> ##[1:2] master_system_reset)
		else $error("reset source did not raise system reset");
	a_por_release: assert property ($fell(master_system_reset) && por_seq
		|-> hi_cnt >= 32'd3000 + st && hi_cnt <= 32'd3016 + st)
		else $error("power-on release time wrong");
	a_int_release: assert property ($fell(master_system_reset) && !por_seq
		|-> hi_cnt >= 32'd2000)
		else $error("internal reset time too short");
	a_cpu_needs_clk: assert property (cpu_run |-> sys_clk_ready || $past(sys_clk_ready))
		else $error("cpu runs without clock");
	a_wdt_fuse_on: assert property (watchdog_fuse_enable && $past(watchdog_fuse_enable)
		&& !$past(rst) |-> watchdog_enable)
		else $error("watchdog off with fuse set");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h14
		|=> s_axi_rvalid && s_axi_rresp == `RSQ_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_b_after_wr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");

	cover property ($fell(master_system_reset) && por_seq);
	cover property (soft_reset_req ##1 master_system_reset);
	cover property (s_axi_rvalid && s_axi_rresp == `RSQ_RESP_SLVERR);
endmodule

`default_nettype wire

// [testbench/rsq_top_tb.sv]
`default_nettype none
`include "rsq_map.vh"
`define rsq_chk(got, exp) \
begin \
	samples_checked++; \
	if ((got) !== (exp)) \
	begin \
		miscompares++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end

module rsq_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int POWER_UP_TIMER = 50;
	logic        clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, osc_in, watchdog_fuse_enable, regulator_enable, bor, osc_run;
	logic        clk_switch_enable, pri_is_crystal, clock_fail_monitor_en;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  initial_osc_select;
	logic [8:0]  src;
	logic [1:0]  r;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         master_system_reset, cpu_run, sys_clk_ready, watchdog_enable;
	wire         regulator_sleep_keep, clock_monitor_active, clock_fail_switched;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [2:0]   current_osc_select;
	int          samples_checked, miscompares, n, i;
	int          fbit[9] = '{4, 6, 15, 14, 14, 9, 3, 2, 7};

	rsq_top #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .CLOCK_FAIL_MONITOR_CYCLES(20)) i_rsq_top (.clk, .rst, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .master_clear_pin_n(~src[8]), .brownout_in(bor), .osc_in,
		.watchdog_timeout(src[0]), .soft_reset_req(src[1]), .trap_conflict_req(src[2]),
		.bad_opcode_req(src[3]), .uninit_wreg_req(src[4]), .config_mismatch_req(src[5]),
		.sleep_instr(src[6]), .idle_instr(src[7]), .watchdog_fuse_enable, .regulator_enable,
		.clk_switch_enable, .initial_osc_select, .pri_is_crystal, .clock_fail_monitor_en,
		.master_system_reset, .cpu_run, .sys_clk_ready, .current_osc_select,
		.watchdog_enable, .regulator_sleep_keep, .clock_monitor_active, .clock_fail_switched);

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw;
		@(posedge clk);
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw)
		begin
			@(posedge clk);
			if (pa && s_axi_awready)
			begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready)
			begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge clk);
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// rready comes late on purpose so the slave must hold its answer
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
			@(posedge clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge clk);
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic t_por;
		n = 0;
		while (master_system_reset === 1'b1 && n < 9000)
		begin
			@(posedge clk);
			n++;
			if (n == 1500)
				`rsq_chk(sys_clk_ready, 1'b0);
		end
		`rsq_chk(n >= 3000 + POWER_UP_TIMER && n <= 3016 + POWER_UP_TIMER, 1'b1);
		repeat (3) @(posedge clk);
		`rsq_chk(sys_clk_ready, 1'b1);
		`rsq_chk(clock_monitor_active, 1'b0);
		repeat (30) @(posedge clk);
		`rsq_chk(clock_monitor_active, 1'b1);
		`rsq_chk(clock_fail_switched, 1'b0);
		`rsq_chk(cpu_run, 1'b1);
		`rsq_chk(current_osc_select, `RSQ_OSC_PRI);
		rd(`RSQ_OFS_STATUS);
		`rsq_chk(d, 32'h0000_0003);
		$display("test por done");
	endtask

	task automatic t_soft;
		wr(`RSQ_OFS_STATUS, 32'h0000_01E0);
		`rsq_chk(r, `RSQ_RESP_OKAY);
		repeat (4) @(posedge clk);
		`rsq_chk(master_system_reset, 1'b0);
		`rsq_chk(watchdog_enable, 1'b1);
		`rsq_chk(regulator_sleep_keep, 1'b1);
		rd(`RSQ_OFS_STATUS);
		`rsq_chk(d, 32'h0000_01E0);
		watchdog_fuse_enable <= 1'b1;
		wr(`RSQ_OFS_STATUS, 32'h0000_0000);
		repeat (2) @(posedge clk);
		`rsq_chk(watchdog_enable, 1'b1);
		watchdog_fuse_enable <= 1'b0;
		wr(`RSQ_OFS_CALIB, 32'h0000_1234);
		rd(8'h20);
		`rsq_chk(r, `RSQ_RESP_SLVERR);
		`rsq_chk(d, 32'h0000_0000);
		wr(`RSQ_OFS_SEQ, 32'h0000_0001);
		`rsq_chk(r, `RSQ_RESP_SLVERR);
		$display("test soft done");
	endtask

	task automatic t_sources;
		initial_osc_select <= `RSQ_OSC_FRC;
		for (i = 0; i < 9; i++)
		begin
			clk_switch_enable <= (i < 4);
			wr(`RSQ_OFS_STATUS, 32'h0000_4000);
			src <= 9'h001 << i;
			repeat (3) @(posedge clk);
			src <= 9'h000;
			if (i != 6 && i != 7)
			begin
				repeat (4) @(posedge clk);
				n = 0;
				while (master_system_reset === 1'b1 && n < 5000)
				begin
					@(posedge clk);
					n++;
				end
				`rsq_chk(n >= 1980 && n <= 2040, 1'b1);
			end
			repeat (3) @(posedge clk);
			`rsq_chk(cpu_run, 1'b1);
			`rsq_chk(current_osc_select, i < 4 ? `RSQ_OSC_PRI : `RSQ_OSC_FRC);
			rd(`RSQ_OFS_STATUS);
			`rsq_chk(d[15:0], 16'h4000 | (16'h0001 << fbit[i]));
		end
		rd(`RSQ_OFS_CALIB);
		`rsq_chk(d, 32'h0000_1234);
		$display("test sources done");
	endtask

	// supply dip with a dead crystal: monitor must fall back to the fast rc
	task automatic t_bor;
		initial_osc_select <= `RSQ_OSC_PRI;
		osc_run <= 1'b0;
		bor <= 1'b1;
		repeat (3) @(posedge clk);
		bor <= 1'b0;
		repeat (4) @(posedge clk);
		n = 0;
		while (master_system_reset === 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		`rsq_chk(n >= 1990 + POWER_UP_TIMER && n <= 2016 + POWER_UP_TIMER, 1'b1);
		`rsq_chk(cpu_run, 1'b0);
		repeat (30) @(posedge clk);
		`rsq_chk(clock_fail_switched, 1'b1);
		`rsq_chk(current_osc_select, `RSQ_OSC_FRC);
		`rsq_chk(cpu_run, 1'b1);
		rd(`RSQ_OFS_OSCCTL);
		`rsq_chk(d, 32'h0000_0008);
		rd(`RSQ_OFS_STATUS);
		`rsq_chk(d, 32'h0000_4082);
		$display("test bor done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		osc_in <= osc_run & ~osc_in;

	initial
	begin
		#500_000;
		miscompares++;
		test_done();
	end

	initial
	begin
		{rst, ce, osc_in, src, s_axi_wstrb} = {1'b1, 1'b1, 1'b0, 9'h000, 4'hF};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		{watchdog_fuse_enable, regulator_enable, clk_switch_enable} = 3'b001;
		{pri_is_crystal, clock_fail_monitor_en, bor, osc_run} = 4'b1101;
		initial_osc_select = `RSQ_OSC_PRI;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_por();
		t_soft();
		t_sources();
		t_bor();
		test_done();
	end
endmodule

bind rsq_top rsq_top_checker #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) i_rsq_top_checker (.clk, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .soft_reset_req, .watchdog_fuse_enable, .regulator_enable,
	.master_system_reset, .cpu_run, .sys_clk_ready, .watchdog_enable);

`default_nettype wire
